// >>> stl_defines.svh
// Constants for the link-tunnel block: mode codes, frame timing, buffer sizes, idle levels.
// Included by the package, the block, the checker and the bench; the guard makes repeat inclusion in one unit harmless.
`ifndef STL_DEFINES_SVH
`define STL_DEFINES_SVH

// Mode codes of the fast control channel mode field.
`define STL_MODE_FWD 3'h6
`define STL_MODE_REV 3'h7

// Back channel frame period at the slowest rate, in nanoseconds, and the clock period.
`define STL_BC_FRAME_NS 7500
`define STL_CLK_NS 40
// Cycles per back channel frame, a period that is never exceeded, so it rounds down.
`define STL_BC_FRAME_CYC (`STL_BC_FRAME_NS / `STL_CLK_NS)
`define STL_FRAME_W 10

// Sample buffer depth and the width of its fill counter.
`define STL_BUF_DEPTH 8
`define STL_CNT_W 4
`define STL_CNT_ONE 4'h1
`define STL_CNT_ZERO 4'h0

// Clock cycles per half period of the rebuilt reverse SPI clock.
`define STL_HALF_CYC 3'h2
`define STL_TMR_W 3
`define STL_TMR_ONE 3'h1

// Idle levels of the rebuilt SPI pins: select high, clock and data low.
`define STL_IDLE_SS_N 1'h1
`define STL_IDLE_SCLK 1'h0
`define STL_IDLE_MOSI 1'h0

`endif

// >>> stl_pkg.sv
// Types shared by the link-tunnel block: pin groups, frame fields, state.
// Assumes the defines header is available on the include path.
`include "stl_defines.svh"

package stl_pkg;

  // One set of SPI master signals, or their slot in a forward frame.
  typedef struct packed {
    logic sclk;  // SPI clock level.
    logic mosi;  // Master out, slave in.
    logic ss_n;  // Slave select, active low.
  } stl_spi_s;

  // One back channel frame of SPI content, marked by a toggle.
  typedef struct packed {
    logic toggle;    // Flips once per new frame.
    logic ss_n;      // Slave select state carried in every frame.
    logic has_data;  // A data sample is present.
    logic data;      // The data sample itself.
  } stl_bframe_s;

  // Reverse regeneration sequencer, one-hot.
  typedef enum logic [2:0] {
    STL_IDLE = 3'h1,
    STL_DATA = 3'h2,
    STL_HIGH = 3'h4
  } stl_regen_e;

  // All state of the block.
  typedef struct packed {
    stl_spi_s fwd_m1, fwd_m2;         // Master pins at serializer, synchroniser.
    stl_spi_s fwd_f1, fwd_f2;         // Forward frame at deserializer, synchroniser.
    stl_spi_s fwd_frame;              // Forward frame bits sent out.
    stl_spi_s fwd_regen;              // Rebuilt forward SPI pins.
    logic fwd_clk_dly;                // Forward clock delayed by one cycle.
    stl_spi_s rev_m1, rev_m2;         // Master pins at deserializer, synchroniser.
    logic rev_sclk_prev;              // Last synced reverse clock for edge detect.
    logic [`STL_BUF_DEPTH-1:0] tx_buf;  // Captured samples awaiting the back channel.
    logic [`STL_CNT_W-1:0] tx_cnt;    // Fill of tx_buf.
    logic [`STL_FRAME_W-1:0] frame_tmr;  // Back channel frame timer.
    stl_bframe_s bframe;              // Back channel frame sent out.
    stl_bframe_s bf1, bf2;            // Received back channel frame synchroniser.
    logic bf_toggle_prev;             // Last taken toggle.
    logic [`STL_BUF_DEPTH-1:0] rx_buf;  // Received samples awaiting regeneration.
    logic [`STL_CNT_W-1:0] rx_cnt;    // Fill of rx_buf.
    stl_regen_e regen_st;             // Reverse sequencer state.
    logic [`STL_TMR_W-1:0] regen_tmr;  // Half-period timer.
    stl_spi_s rev_regen;              // Rebuilt reverse SPI pins.
  } stl_state_s;

endpackage : stl_pkg

// >>> stl_spi_link_tunnel.sv
// SPI tunnel over the secondary lane: forward and reverse paths of both link ends.
// Assumes mode is set by the controller after lock, and that link-side inputs are
// asynchronous to clk; every one of them passes two flip-flops before use.
//
// Contract
// - Serializer oversamples master pins into forward frame.
// - Deserializer rebuilds pins, holds data while clock high.
// - Rebuilt forward clock lags data by one cycle.
// - Reverse select and clock synchronised before use.
// - Capture data on active clock edge, buffer it.
// - Every back frame carries slave select state.
// - At most one data sample per back frame.
// - Serializer rebuilds buffered reverse data in bursts.
// - Tunnel reaches only external devices, never registers.
`timescale 1ns/100ps
`include "stl_defines.svh"

module stl_spi_link_tunnel
  import stl_pkg::*;
#(
  parameter logic [`STL_FRAME_W-1:0] BC_FRAME_CYC = `STL_FRAME_W'(`STL_BC_FRAME_CYC)
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [2:0] fast_ctrl_channel_mode,  // Channel mode selecting the tunnel.
  input wire stl_spi_s fwd_master_in,      // SPI master at the serializer.
  output stl_spi_s fwd_frame_out,          // SPI bits placed in the forward frame.
  input wire stl_spi_s fwd_frame_in,       // SPI bits taken from the forward frame.
  output stl_spi_s fwd_regen_out,          // Rebuilt pins toward the slave, deserializer.
  input wire stl_spi_s rev_master_in,      // SPI master at the deserializer.
  output stl_bframe_s bframe_out,          // Back channel SPI content sent.
  input wire stl_bframe_s bframe_in,       // Back channel SPI content received.
  output stl_spi_s rev_regen_out           // Rebuilt pins toward the slave, serializer.
);

  // Idle level of a rebuilt pin group.
  localparam stl_spi_s IDLE_PINS = '{sclk: `STL_IDLE_SCLK, mosi: `STL_IDLE_MOSI,
                                     ss_n: `STL_IDLE_SS_N};

  stl_state_s st_reg;   // Registered state.
  stl_state_s st_next;  // Next state.
  logic fwd_on;         // Forward tunnelling selected.
  logic rev_on;         // Reverse tunnelling selected.
  logic cap_edge;       // Active reverse clock edge seen this cycle.
  logic frame_end;      // Back channel frame boundary this cycle.
  logic bf_new;         // A new back channel frame was received.
  logic rx_pop;         // Regenerator takes a sample this cycle.
  logic tx_pop;         // Frame sender takes a sample this cycle.

  // Removes the oldest bit of a buffer by shifting toward bit zero.
  function automatic logic [`STL_BUF_DEPTH-1:0] buf_shift(
    input logic [`STL_BUF_DEPTH-1:0] b
  );
    buf_shift = {1'b0, b[`STL_BUF_DEPTH-1:1]};
  endfunction : buf_shift

  // Writes a bit at a fill position after an optional pop, and returns the new buffer.
  function automatic logic [`STL_BUF_DEPTH-1:0] buf_update(
    input logic [`STL_BUF_DEPTH-1:0] b,
    input logic [`STL_CNT_W-1:0] cnt,
    input logic pop,
    input logic push,
    input logic bit_in
  );
    logic [`STL_BUF_DEPTH-1:0] r;
    logic [`STL_CNT_W-1:0] pos;
    r = pop ? buf_shift(b) : b;
    pos = pop ? cnt - `STL_CNT_ONE : cnt;
    if (push && (pos < `STL_CNT_W'(`STL_BUF_DEPTH)))
    begin
      r[pos[`STL_CNT_W-2:0]] = bit_in;
    end
    buf_update = r;
  endfunction : buf_update

  // Fill count after an optional pop and an optional push; a full buffer drops the push.
  function automatic logic [`STL_CNT_W-1:0] cnt_update(
    input logic [`STL_CNT_W-1:0] cnt,
    input logic pop,
    input logic push
  );
    logic [`STL_CNT_W-1:0] c;
    c = pop ? cnt - `STL_CNT_ONE : cnt;
    if (push && (c < `STL_CNT_W'(`STL_BUF_DEPTH)))
    begin
      c = c + `STL_CNT_ONE;
    end
    cnt_update = c;
  endfunction : cnt_update

  // Mode decode and the events that drive the buffers.
  assign fwd_on = (fast_ctrl_channel_mode == `STL_MODE_FWD);
  assign rev_on = (fast_ctrl_channel_mode == `STL_MODE_REV);
  assign cap_edge = rev_on && st_reg.rev_m2.sclk && !st_reg.rev_sclk_prev;
  assign frame_end = (st_reg.frame_tmr == '0);
  assign tx_pop = rev_on && frame_end && (st_reg.tx_cnt != `STL_CNT_ZERO);
  assign bf_new = rev_on && (st_reg.bf2.toggle != st_reg.bf_toggle_prev);
  assign rx_pop = (st_reg.regen_st == STL_IDLE) && (st_reg.rx_cnt != `STL_CNT_ZERO);

  // Next-state logic for both directions. The tunnel only moves pin levels between
  // external parts; nothing here reaches a local register.
  always_comb
  begin
    st_next = st_reg;
    // Two-stage synchronisers; the first stage feeds only the second.
    st_next.fwd_m1 = fwd_master_in;
    st_next.fwd_m2 = st_reg.fwd_m1;
    st_next.fwd_f1 = fwd_frame_in;
    st_next.fwd_f2 = st_reg.fwd_f1;
    st_next.rev_m1 = rev_master_in;
    st_next.rev_m2 = st_reg.rev_m1;
    st_next.bf1 = bframe_in;
    st_next.bf2 = st_reg.bf1;
    st_next.rev_sclk_prev = st_reg.rev_m2.sclk;

    // Forward path, serializer end: each sampled pin gets its own frame bit.
    if (fwd_on)
    begin
      st_next.fwd_frame = st_reg.fwd_m2;
    end
    else
    begin
      st_next.fwd_frame = IDLE_PINS;
    end

    // Forward path, deserializer end: clock lags data by one cycle, data held while high.
    if (fwd_on)
    begin
      st_next.fwd_clk_dly = st_reg.fwd_f2.sclk;
      st_next.fwd_regen.sclk = st_reg.fwd_clk_dly;
      st_next.fwd_regen.ss_n = st_reg.fwd_f2.ss_n;
      if (!st_reg.fwd_regen.sclk)
      begin
        st_next.fwd_regen.mosi = st_reg.fwd_f2.mosi;
      end
    end
    else
    begin
      st_next.fwd_clk_dly = `STL_IDLE_SCLK;
      st_next.fwd_regen = IDLE_PINS;
    end

    // Reverse path, deserializer end: capture on rising clock edge into the buffer.
    st_next.tx_buf = buf_update(st_reg.tx_buf, st_reg.tx_cnt, tx_pop, cap_edge,
                                st_reg.rev_m2.mosi);
    st_next.tx_cnt = cnt_update(st_reg.tx_cnt, tx_pop, cap_edge);

    // Frame timer and sender: one frame per period, at most one sample in it.
    if (!rev_on || frame_end)
    begin
      st_next.frame_tmr = BC_FRAME_CYC - `STL_FRAME_W'(1);
    end
    else
    begin
      st_next.frame_tmr = st_reg.frame_tmr - `STL_FRAME_W'(1);
    end
    if (rev_on && frame_end)
    begin
      st_next.bframe.toggle = !st_reg.bframe.toggle;
      st_next.bframe.ss_n = st_reg.rev_m2.ss_n;
      st_next.bframe.has_data = tx_pop;
      st_next.bframe.data = tx_pop ? st_reg.tx_buf[0] : 1'b0;
    end
    else if (!rev_on)
    begin
      st_next.bframe.ss_n = `STL_IDLE_SS_N;
      st_next.bframe.has_data = 1'b0;
      st_next.bframe.data = 1'b0;
    end

    // Reverse path, serializer end: take each new frame. An asserting select applies at
    // once, so it may show before the data of a later frame. A releasing select waits
    // until every bit already received has been clocked out, so no bit loses it.
    if (bf_new)
    begin
      st_next.bf_toggle_prev = st_reg.bf2.toggle;
      if (!st_reg.bf2.ss_n)
      begin
        st_next.rev_regen.ss_n = st_reg.bf2.ss_n;
      end
    end
    else if (st_reg.bf2.ss_n && (st_reg.rx_cnt == `STL_CNT_ZERO) &&
             (st_reg.regen_st == STL_IDLE))
    begin
      // Buffer drained and sequencer idle: the release may now show.
      st_next.rev_regen.ss_n = st_reg.bf2.ss_n;
    end
    st_next.rx_buf = buf_update(st_reg.rx_buf, st_reg.rx_cnt, rx_pop,
                                bf_new && st_reg.bf2.has_data, st_reg.bf2.data);
    st_next.rx_cnt = cnt_update(st_reg.rx_cnt, rx_pop, bf_new && st_reg.bf2.has_data);

    // Regeneration sequencer: data out, then a clock pulse; runs back to back in bursts.
    unique case (st_reg.regen_st)
      STL_IDLE:
      begin
        if (rx_pop)
        begin
          st_next.rev_regen.mosi = st_reg.rx_buf[0];
          st_next.regen_tmr = `STL_HALF_CYC;
          st_next.regen_st = STL_DATA;
        end
      end
      STL_DATA:
      begin
        // Data has settled for a half period; raise the clock.
        if (st_reg.regen_tmr == `STL_TMR_ONE)
        begin
          st_next.rev_regen.sclk = 1'b1;
          st_next.regen_tmr = `STL_HALF_CYC;
          st_next.regen_st = STL_HIGH;
        end
        else
        begin
          st_next.regen_tmr = st_reg.regen_tmr - `STL_TMR_ONE;
        end
      end
      STL_HIGH:
      begin
        // Clock high for a half period; data is held, then the clock falls.
        if (st_reg.regen_tmr == `STL_TMR_ONE)
        begin
          st_next.rev_regen.sclk = 1'b0;
          st_next.regen_st = STL_IDLE;
        end
        else
        begin
          st_next.regen_tmr = st_reg.regen_tmr - `STL_TMR_ONE;
        end
      end
    endcase

    // Leaving reverse mode flushes everything and parks the pins.
    if (!rev_on)
    begin
      st_next.tx_cnt = `STL_CNT_ZERO;
      st_next.rx_cnt = `STL_CNT_ZERO;
      st_next.regen_st = STL_IDLE;
      st_next.rev_regen = IDLE_PINS;
      st_next.bf_toggle_prev = st_reg.bf2.toggle;
    end
  end

  // State register with synchronous reset to idle pin levels.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_reg <= '0;
      // Synchronisers start at idle pin levels, so no false select follows reset.
      st_reg.fwd_m1 <= IDLE_PINS;
      st_reg.fwd_m2 <= IDLE_PINS;
      st_reg.fwd_f1 <= IDLE_PINS;
      st_reg.fwd_f2 <= IDLE_PINS;
      st_reg.rev_m1 <= IDLE_PINS;
      st_reg.rev_m2 <= IDLE_PINS;
      st_reg.bf1.ss_n <= `STL_IDLE_SS_N;
      st_reg.bf2.ss_n <= `STL_IDLE_SS_N;
      st_reg.fwd_frame <= IDLE_PINS;
      st_reg.fwd_regen <= IDLE_PINS;
      st_reg.rev_regen <= IDLE_PINS;
      st_reg.bframe.ss_n <= `STL_IDLE_SS_N;
      st_reg.regen_st <= STL_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from state flip-flops.
  assign fwd_frame_out = st_reg.fwd_frame;
  assign fwd_regen_out = st_reg.fwd_regen;
  assign bframe_out = st_reg.bframe;
  assign rev_regen_out = st_reg.rev_regen;

endmodule : stl_spi_link_tunnel

// >>> stl_tunnel_properties.sv
// Checker of the SPI link tunnel, bound to the top module's ports.
// Assumes the tunnel's frame ports are looped back by the bench.
`timescale 1ns/100ps
`include "stl_defines.svh"
module stl_tunnel_properties
  import stl_pkg::*;
#(
  parameter logic [`STL_FRAME_W-1:0] BC_FRAME_CYC = `STL_FRAME_W'(`STL_BC_FRAME_CYC)
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [2:0] fast_ctrl_channel_mode,
  input wire stl_spi_s fwd_master_in,
  input wire stl_spi_s fwd_frame_out,
  input wire stl_spi_s fwd_frame_in,
  input wire stl_spi_s fwd_regen_out,
  input wire stl_spi_s rev_master_in,
  input wire stl_bframe_s bframe_out,
  input wire stl_bframe_s bframe_in,
  input wire stl_spi_s rev_regen_out
);
  localparam stl_spi_s IDLE = {`STL_IDLE_SCLK, `STL_IDLE_MOSI, `STL_IDLE_SS_N};
  logic [3:0] fa_reg; // Cycles spent in forward mode, saturating.
  logic [3:0] ra_reg; // Cycles spent in reverse mode, saturating.
  logic [`STL_FRAME_W-1:0] gap_reg; // Cycles since the last back frame toggle.
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Mode age counters and the frame gap counter.
  always_ff @(posedge clk)
  begin
    fa_reg <= (srst || fast_ctrl_channel_mode != `STL_MODE_FWD) ? 4'h0 : fa_reg + {3'h0, ~&fa_reg};
    ra_reg <= (srst || fast_ctrl_channel_mode != `STL_MODE_REV) ? 4'h0 : ra_reg + {3'h0, ~&ra_reg};
    if (srst || $changed(bframe_out.toggle))
      gap_reg <= srst ? '1 : '0;
    else if (~&gap_reg)
      gap_reg <= gap_reg + 1'b1;
  end
  property p_fwd_frame;
    fa_reg >= 4 |-> fwd_frame_out == $past(fwd_master_in, 3);
  endproperty
  a_fwd_frame: assert property (p_fwd_frame) else $error("forward frame bits wrong");
  property p_fwd_mosi;
    fa_reg >= 5 && !$past(fwd_regen_out.sclk) |->
      fwd_regen_out.mosi == $past(fwd_frame_in.mosi, 3);
  endproperty
  a_fwd_mosi: assert property (p_fwd_mosi) else $error("rebuilt data late");
  property p_fwd_ss;
    fa_reg >= 5 |-> fwd_regen_out.ss_n == $past(fwd_frame_in.ss_n, 3);
  endproperty
  a_fwd_ss: assert property (p_fwd_ss) else $error("rebuilt select wrong");
  property p_fwd_clk;
    fa_reg >= 6 |-> fwd_regen_out.sclk == $past(fwd_frame_in.sclk, 4);
  endproperty
  a_fwd_clk: assert property (p_fwd_clk) else $error("rebuilt clock not delayed");
  property p_fwd_hold;
    fa_reg >= 2 && fwd_regen_out.sclk && $past(fwd_regen_out.sclk) |->
      $stable(fwd_regen_out.mosi);
  endproperty
  a_fwd_hold: assert property (p_fwd_hold) else $error("data moved while clock high");
  property p_idle;
    $past(fa_reg) == 0 && fa_reg == 0 |-> fwd_frame_out == IDLE && fwd_regen_out == IDLE;
  endproperty
  a_idle: assert property (p_idle) else $error("forward pins not idle");
  property p_rev_idle;
    $past(ra_reg) == 0 && ra_reg == 0 |->
      rev_regen_out == IDLE && bframe_out.ss_n && !bframe_out.has_data;
  endproperty
  a_rev_idle: assert property (p_rev_idle) else $error("reverse pins not idle");
  property p_gap;
    ra_reg == 15 && $changed(bframe_out.toggle) |-> gap_reg == BC_FRAME_CYC - 1;
  endproperty
  a_gap: assert property (p_gap) else $error("back frames too close");
  property p_bss;
    ra_reg == 15 && $changed(bframe_out.toggle) |->
      bframe_out.ss_n == $past(rev_master_in.ss_n, 3);
  endproperty
  a_bss: assert property (p_bss) else $error("back frame select wrong");
  property p_pulse;
    ra_reg >= 4 && $rose(rev_regen_out.sclk) |=> rev_regen_out.sclk ##1 !rev_regen_out.sclk;
  endproperty
  a_pulse: assert property (p_pulse) else $error("reverse clock pulse width wrong");
  property p_rev_ss;
    ra_reg >= 4 && $rose(rev_regen_out.sclk) |-> !rev_regen_out.ss_n;
  endproperty
  a_rev_ss: assert property (p_rev_ss) else $error("reverse clock outside select");
  c_fwd: cover property ($rose(fwd_regen_out.sclk));
  c_data: cover property ($rose(bframe_out.has_data));
  c_rev: cover property ($rose(rev_regen_out.sclk));
endmodule : stl_tunnel_properties
bind stl_spi_link_tunnel stl_tunnel_properties #(.BC_FRAME_CYC(BC_FRAME_CYC)) u_props (.clk(clk),
  .srst(srst), .fast_ctrl_channel_mode(fast_ctrl_channel_mode), .fwd_master_in(fwd_master_in),
  .fwd_frame_out(fwd_frame_out), .fwd_frame_in(fwd_frame_in), .fwd_regen_out(fwd_regen_out),
  .rev_master_in(rev_master_in), .bframe_out(bframe_out), .bframe_in(bframe_in),
  .rev_regen_out(rev_regen_out));

// >>> stl_rev_master_model.sv
// SPI master at the deserializer, driving the reverse tunnel input.
// Assumes go is a one-cycle pulse given while busy is low.
`timescale 1ns/100ps
module stl_rev_master_model
  import stl_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] tx_byte,
  output logic busy,
  output stl_spi_s spi
);
  // Idle: select high and clock still.
  initial
  begin
    busy = 1'h0;
    spi = {1'h0, 1'h0, 1'h1};
  end
  // One byte per go, MSB first, clock period 320 ns.
  always @(posedge clk)
  begin
    if (go && !busy)
    begin
      busy <= 1'h1;
      spi.ss_n <= 1'h0;
      repeat (8) @(posedge clk);
      for (int i = 7; i >= 0; i--)
      begin
        spi.mosi <= tx_byte[i];
        repeat (4) @(posedge clk);
        spi.sclk <= 1'h1; // Slow edges leave time for a round trip.
        repeat (4) @(posedge clk);
        spi.sclk <= 1'h0;
      end
      repeat (4) @(posedge clk);
      spi.ss_n <= 1'h1;
      spi.mosi <= ~tx_byte[0]; // Released line shows the inverse of the last bit.
      repeat (16) @(posedge clk); // Select stays high two frames.
      busy <= 1'h0;
    end
  end
endmodule : stl_rev_master_model

// >>> stl_testbench.sv
// Self-checking bench of the SPI link tunnel with both frame ports looped back.
// Assumes the partner model drives the reverse master pins.
`timescale 1ns/100ps
`include "stl_defines.svh"
`define CHK(w, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", w, e, g); end end
module testbench;
  import stl_pkg::*;
  logic clk, srst, go, busy, pf, pr, ss_bad;
  logic [2:0] mode;
  logic [7:0] tx, fb, rb;
  int mismatches = 0, n_compared = 0, fc = 0, rc = 0;
  stl_spi_s fm, flink, freg, rm, rreg;
  stl_bframe_s blink;
  stl_spi_link_tunnel #(.BC_FRAME_CYC(`STL_FRAME_W'(8))) DUT (.clk(clk), .srst(srst),
    .fast_ctrl_channel_mode(mode), .fwd_master_in(fm), .fwd_frame_out(flink),
    .fwd_frame_in(flink), .fwd_regen_out(freg), .rev_master_in(rm), .bframe_out(blink),
    .bframe_in(blink), .rev_regen_out(rreg));
  stl_rev_master_model u_master (.clk(clk), .go(go), .tx_byte(tx), .busy(busy), .spi(rm));
  // Collects bits at each rising rebuilt clock.
  always @(posedge clk)
  begin
    pf <= freg.sclk;
    pr <= rreg.sclk;
    if (freg.sclk && !pf)
    begin
      fb <= {fb[6:0], freg.mosi};
      fc++;
    end
    if (rreg.sclk && !pr)
    begin
      rb <= {rb[6:0], rreg.mosi};
      rc++;
      if (rreg.ss_n !== 1'h0)
        ss_bad <= 1'h1;
    end
  end
  // Reset, then every output must be idle.
  task automatic t_idle;
    srst <= 1'h1;
    repeat (5) @(posedge clk);
    srst <= 1'h0;
    #1;
    `CHK("fwd", 6'h09, {flink, freg})
    `CHK("rev", 5'h06, {rreg, blink.ss_n, blink.has_data})
    @(posedge clk);
  endtask : t_idle
  // Sends one byte from the serializer-side master.
  task automatic fwd_send(input logic [7:0] b);
    @(posedge clk);
    fm.ss_n <= 1'h0;
    repeat (4) @(posedge clk);
    // Clock period 320 ns; data changes as the clock falls.
    for (int i = 7; i >= 0; i--)
    begin
      fm.mosi <= b[i];
      repeat (4) @(posedge clk);
      fm.sclk <= 1'h1;
      repeat (4) @(posedge clk);
      fm.sclk <= 1'h0;
    end
    repeat (4) @(posedge clk);
    fm.ss_n <= 1'h1;
    fm.mosi <= ~b[0];
    repeat (12) @(posedge clk);
  endtask : fwd_send
  // Forward bytes arrive whole; a disabled tunnel passes nothing.
  task automatic t_forward;
    int c0;
    mode <= `STL_MODE_FWD;
    for (int i = 0; i < 2; i++)
    begin
      c0 = fc;
      fwd_send(i ? 8'h5A : 8'hA5);
      `CHK("fwd count", c0 + 8, fc)
      `CHK("fwd byte", i ? 8'h5A : 8'hA5, fb)
    end
    mode <= 3'h0;
    c0 = fc;
    fwd_send(8'hFF);
    `CHK("off count", c0, fc)
  endtask : t_forward
  // One reverse byte through the back channel; abort cuts it short.
  task automatic rev_send(input logic [7:0] b, input logic abort);
    int c0, n;
    c0 = rc;
    tx <= b;
    go <= 1'h1;
    @(posedge clk) go <= 1'h0;
    repeat (abort ? 40 : 1) @(posedge clk);
    if (abort)
    begin
      mode <= 3'h0;
      repeat (3) @(posedge clk);
      #1;
      `CHK("abort", 5'h06, {rreg, blink.ss_n, blink.has_data})
    end
    for (n = 0; busy !== 1'h0 && n < 500; n++)
      @(posedge clk);
    repeat (40) @(posedge clk);
    mode <= `STL_MODE_REV;
    if (!abort)
    begin
      `CHK("rev count", c0 + 8, rc)
      `CHK("rev byte", b, rb)
      `CHK("rev select", 1'h0, ss_bad)
    end
    repeat (24) @(posedge clk);
  endtask : rev_send
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end
  initial
  begin
    {srst, go, mode, tx, pf, pr, ss_bad} = '0;
    fm = {1'h0, 1'h0, 1'h1};
    t_idle();
    t_forward();
    t_idle();
    mode <= `STL_MODE_REV;
    repeat (24) @(posedge clk);
    rev_send(8'hC3, 1'h0);
    rev_send(8'hFF, 1'h1);
    rev_send(8'h96, 1'h0);
    conclude();
  end
endmodule : testbench
